// ==== verilog/tcc_timer.sv ====
`timescale 1ns/1ps
module tcc_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [tcc_pkg::DATA_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [tcc_pkg::DATA_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [tcc_pkg::DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Processor modes
  input wire logic wait_mode_in,
  input wire logic debug_mode_in,
  // Timer port pins
  input wire logic [tcc_pkg::NCH-1:0] pin_in,
  input wire logic [tcc_pkg::NCH-1:0] port_direction_bits_in,
  input wire logic [tcc_pkg::NCH-1:0] port_data_in,
  output logic [tcc_pkg::NCH-1:0] pin_out,
  output logic [tcc_pkg::NCH-1:0] pin_oe_out,
  // Requests and ticks
  output logic [tcc_pkg::NCH-1:0] channel_irq_out,
  output logic overflow_irq_out,
  output logic accum_div64_tick_out
);
  import tcc_pkg::*;

  typedef struct packed {
    tcc_bus_t bus;
    logic [IDX_W-1:0] addr;
    logic [DATA_W-1:0] hrdata;
    logic [NCH-1:0] capture_or_compare_select;
    logic timer_run_enable;
    logic wait_stop_select;
    logic debug_halt_select;
    logic fast_flag_clear;
    logic [NCH-1:0] compare_mode_bit;
    logic [NCH-1:0] compare_level_bit;
    logic [NCH-1:0][1:0] capture_edge_code;
    logic [NCH-1:0] channel_irq_enable;
    logic overflow_irq_enable;
    logic counter_reset_on_ch7;
    logic [2:0] prescale_select;
    logic [NCH-1:0] channel_event_flag;
    logic counter_wrap_flag;
    logic [NCH-1:0][CNT_W-1:0] channel_value;
    logic [CNT_W-1:0] free_running_counter;
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] compare_out;
    logic accum_enable;
    logic accum_gated;
    logic accum_edge;
    logic accum_overflow_flag;
    logic accum_input_flag;
    logic [CNT_W-1:0] accum_counter;
  } tcc_state_t;

  tcc_state_t s;
  tcc_state_t next_s;
  logic timer_run;
  logic accum_run;
  logic count_tick;
  logic slow_tick;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] set_ch;
  logic [NCH-1:0] clr_ch;
  logic set_wrap;
  logic clr_wrap;
  logic set_acc_ovf;
  logic set_acc_in;
  logic clr_acc_ovf;
  logic clr_acc_in;
  logic acc_edge_hit;
  logic acc_level_hit;
  logic [3:0] ch_dec;
  logic [7:0] wbyte;
  logic [DATA_W-1:0] rdata;

  // Timer stops for disable, wait with stop select, debug with halt select
  assign timer_run = s.timer_run_enable & ~(wait_mode_in & s.wait_stop_select)
                     & ~(debug_mode_in & s.debug_halt_select);
  // Debug halt deliberately absent here: event counting carries on
  assign accum_run = s.accum_enable & ~(wait_mode_in & s.wait_stop_select);

  tcc_prescaler #(
    .STAGES(PRE_W)
  ) u_prescaler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(timer_run),
    .sel_in(s.prescale_select),
    .count_tick_out(count_tick),
    .slow_tick_out(slow_tick)
  );

  assign rise = pin_in & ~s.pin_prev;
  assign fall = ~pin_in & s.pin_prev;

  // Read data for the index held in the address phase
  always_comb begin
    rdata = RD_ZERO;
    ch_dec = tcc_ch_decode(s.addr);
    if (ch_dec[3]) begin
      rdata[CNT_W-1:0] = s.channel_value[ch_dec[2:0]];
    end else begin
      case (s.addr)
        IDX_IOS: rdata[7:0] = s.capture_or_compare_select;
        IDX_FREE_CNT: rdata[CNT_W-1:0] = s.free_running_counter;
        IDX_TIMER_SYSTEM_CONTROL: begin
          rdata[TIMER_SYSTEM_CONTROL_RUN_BIT] = s.timer_run_enable;
          rdata[TIMER_SYSTEM_CONTROL_WAIT_BIT] = s.wait_stop_select;
          rdata[TIMER_SYSTEM_CONTROL_DEBUG_BIT] = s.debug_halt_select;
          rdata[TIMER_SYSTEM_CONTROL_FAST_BIT] = s.fast_flag_clear;
        end
        IDX_CMP_UPPER: begin
          for (int k = 0; k < 4; k++) begin
            rdata[2*k+1] = s.compare_mode_bit[4+k];
            rdata[2*k] = s.compare_level_bit[4+k];
          end
        end
        IDX_CMP_LOWER: begin
          for (int k = 0; k < 4; k++) begin
            rdata[2*k+1] = s.compare_mode_bit[k];
            rdata[2*k] = s.compare_level_bit[k];
          end
        end
        IDX_EDGE_UPPER: rdata[7:0] = {s.capture_edge_code[7], s.capture_edge_code[6],
                                      s.capture_edge_code[5], s.capture_edge_code[4]};
        IDX_EDGE_LOWER: rdata[7:0] = {s.capture_edge_code[3], s.capture_edge_code[2],
                                      s.capture_edge_code[1], s.capture_edge_code[0]};
        IDX_CH_IRQ_MASK: rdata[7:0] = s.channel_irq_enable;
        IDX_OVF_PRESCALE: begin
          rdata[OVP_IRQ_BIT] = s.overflow_irq_enable;
          rdata[OVP_CRST_BIT] = s.counter_reset_on_ch7;
          rdata[OVP_PR_LSB +: 3] = s.prescale_select;
        end
        IDX_CH_FLAGS: rdata[7:0] = s.channel_event_flag;
        IDX_OVF_FLAGS: rdata[OVF_FLAG_BIT] = s.counter_wrap_flag;
        IDX_ACC_CTL: begin
          rdata[ACC_EN_BIT] = s.accum_enable;
          rdata[ACC_GATED_BIT] = s.accum_gated;
          rdata[ACC_EDGE_BIT] = s.accum_edge;
        end
        IDX_ACC_FLAGS: begin
          rdata[ACC_OVF_BIT] = s.accum_overflow_flag;
          rdata[ACC_IN_BIT] = s.accum_input_flag;
        end
        IDX_ACC_CNT: rdata[CNT_W-1:0] = s.accum_counter;
        default: rdata = RD_ZERO;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    set_ch = '0;
    clr_ch = '0;
    set_wrap = 1'b0;
    clr_wrap = 1'b0;
    set_acc_ovf = 1'b0;
    set_acc_in = 1'b0;
    clr_acc_ovf = 1'b0;
    clr_acc_in = 1'b0;
    wbyte = hwdata_in[7:0];

    // Bus data phase
    case (s.bus)
      BUS_RD_WAIT: begin
        next_s.hrdata = rdata;
        next_s.bus = BUS_RD_DONE;
        if (s.fast_flag_clear) begin
          if (ch_dec[3] && !s.capture_or_compare_select[ch_dec[2:0]]) begin
            clr_ch[ch_dec[2:0]] = 1'b1;
          end
          if (s.addr == IDX_FREE_CNT) begin
            clr_wrap = 1'b1;
          end
          if (s.addr == IDX_ACC_CNT) begin
            clr_acc_ovf = 1'b1;
            clr_acc_in = 1'b1;
          end
        end
      end
      BUS_WR: begin
        if (ch_dec[3]) begin
          if (s.capture_or_compare_select[ch_dec[2:0]]) begin
            next_s.channel_value[ch_dec[2:0]] = hwdata_in[CNT_W-1:0];
            clr_ch[ch_dec[2:0]] = s.fast_flag_clear;
          end
        end else begin
          case (s.addr)
            IDX_IOS: next_s.capture_or_compare_select = wbyte;
            // Counter is read-only here; the write still counts as an access
            IDX_FREE_CNT: clr_wrap = s.fast_flag_clear;
            IDX_TIMER_SYSTEM_CONTROL: begin
              next_s.timer_run_enable = wbyte[TIMER_SYSTEM_CONTROL_RUN_BIT];
              next_s.wait_stop_select = wbyte[TIMER_SYSTEM_CONTROL_WAIT_BIT];
              next_s.debug_halt_select = wbyte[TIMER_SYSTEM_CONTROL_DEBUG_BIT];
              next_s.fast_flag_clear = wbyte[TIMER_SYSTEM_CONTROL_FAST_BIT];
            end
            IDX_CMP_UPPER: begin
              for (int k = 0; k < 4; k++) begin
                next_s.compare_mode_bit[4+k] = wbyte[2*k+1];
                next_s.compare_level_bit[4+k] = wbyte[2*k];
              end
            end
            IDX_CMP_LOWER: begin
              for (int k = 0; k < 4; k++) begin
                next_s.compare_mode_bit[k] = wbyte[2*k+1];
                next_s.compare_level_bit[k] = wbyte[2*k];
              end
            end
            IDX_EDGE_UPPER: begin
              for (int k = 0; k < 4; k++) begin
                next_s.capture_edge_code[4+k] = wbyte[2*k +: 2];
              end
            end
            IDX_EDGE_LOWER: begin
              for (int k = 0; k < 4; k++) begin
                next_s.capture_edge_code[k] = wbyte[2*k +: 2];
              end
            end
            IDX_CH_IRQ_MASK: next_s.channel_irq_enable = wbyte;
            IDX_OVF_PRESCALE: begin
              next_s.overflow_irq_enable = wbyte[OVP_IRQ_BIT];
              next_s.counter_reset_on_ch7 = wbyte[OVP_CRST_BIT];
              next_s.prescale_select = wbyte[OVP_PR_LSB +: 3];
            end
            // Write-one-to-clear works whether or not fast clearing is on
            IDX_CH_FLAGS: clr_ch = wbyte;
            IDX_OVF_FLAGS: clr_wrap = wbyte[OVF_FLAG_BIT];
            IDX_ACC_CTL: begin
              next_s.accum_enable = wbyte[ACC_EN_BIT];
              next_s.accum_gated = wbyte[ACC_GATED_BIT];
              next_s.accum_edge = wbyte[ACC_EDGE_BIT];
            end
            IDX_ACC_FLAGS: begin
              clr_acc_ovf = wbyte[ACC_OVF_BIT];
              clr_acc_in = wbyte[ACC_IN_BIT];
            end
            IDX_ACC_CNT: begin
              next_s.accum_counter = hwdata_in[CNT_W-1:0];
              clr_acc_ovf = s.fast_flag_clear;
              clr_acc_in = s.fast_flag_clear;
            end
            default: next_s.bus = BUS_WR;
          endcase
        end
      end
      default: next_s.bus = s.bus;
    endcase

    // Address phase; a read costs one wait state so it sees the prior write
    if (s.bus != BUS_RD_WAIT) begin
      if (hsel_in && htrans_in[1] && hready_in) begin
        next_s.addr = haddr_in[IDX_LSB +: IDX_W];
        next_s.bus = hwrite_in ? BUS_WR : BUS_RD_WAIT;
      end else begin
        next_s.bus = BUS_IDLE;
      end
    end

    // Counter and compares, once per prescaled tick
    if (count_tick) begin
      for (int i = 0; i < NCH; i++) begin
        if (s.capture_or_compare_select[i] && s.free_running_counter == s.channel_value[i]) begin
          set_ch[i] = 1'b1;
          case ({s.compare_mode_bit[i], s.compare_level_bit[i]})
            2'b01: next_s.compare_out[i] = ~s.compare_out[i];
            2'b10: next_s.compare_out[i] = 1'b0;
            2'b11: next_s.compare_out[i] = 1'b1;
            default: next_s.compare_out[i] = s.compare_out[i];
          endcase
        end
      end
      // Reset path wins over the wrap, which keeps the flag quiet at all ones
      if (s.counter_reset_on_ch7 && set_ch[NCH-1]) begin
        next_s.free_running_counter = CNT_ZERO;
      end else begin
        next_s.free_running_counter = s.free_running_counter + 1'b1;
        set_wrap = (s.free_running_counter == CNT_MAX);
      end
    end

    // Captures run regardless of timer activity
    for (int i = 0; i < NCH; i++) begin
      if (!s.capture_or_compare_select[i] &&
          ((s.capture_edge_code[i][0] && rise[i]) || (s.capture_edge_code[i][1] && fall[i]))) begin
        next_s.channel_value[i] = s.free_running_counter;
        set_ch[i] = 1'b1;
      end
    end
    next_s.pin_prev = pin_in;

    // Accumulator on channel 7 pin; trailing gate edge equals the event edge
    acc_edge_hit = s.accum_edge ? rise[NCH-1] : fall[NCH-1];
    acc_level_hit = s.accum_edge ? ~pin_in[NCH-1] : pin_in[NCH-1];
    if (accum_run && acc_edge_hit) begin
      set_acc_in = 1'b1;
    end
    if (accum_run && (s.accum_gated ? (slow_tick && acc_level_hit) : acc_edge_hit)) begin
      next_s.accum_counter = s.accum_counter + 1'b1;
      set_acc_ovf = (s.accum_counter == CNT_MAX);
    end

    // Flag update: a set in the same cycle as its clear survives
    next_s.channel_event_flag = (s.channel_event_flag & ~clr_ch) | set_ch;
    next_s.counter_wrap_flag = (s.counter_wrap_flag & ~clr_wrap) | set_wrap;
    next_s.accum_overflow_flag = (s.accum_overflow_flag & ~clr_acc_ovf) | set_acc_ovf;
    next_s.accum_input_flag = (s.accum_input_flag & ~clr_acc_in) | set_acc_in;
  end

  // Pin drive
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (s.capture_or_compare_select[i] && (s.compare_mode_bit[i] || s.compare_level_bit[i])) begin
        pin_oe_out[i] = 1'b1;
        pin_out[i] = s.compare_out[i];
      end else begin
        pin_oe_out[i] = port_direction_bits_in[i];
        pin_out[i] = port_data_in[i];
      end
    end
  end

  assign channel_irq_out = s.channel_event_flag & s.channel_irq_enable;
  assign overflow_irq_out = s.counter_wrap_flag & s.overflow_irq_enable;
  assign accum_div64_tick_out = slow_tick;
  assign hrdata_out = s.hrdata;
  assign hreadyout_out = (s.bus != BUS_RD_WAIT);
  assign hresp_out = 1'b0;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : tcc_timer

// ==== verilog/tcc_pkg.sv ====
package tcc_pkg;

  // Bus and datapath widths
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int CNT_W = 16;
  localparam int NCH = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_IOS = 8'h80;
  localparam logic [IDX_W-1:0] IDX_FREE_CNT = 8'h84;
  localparam logic [IDX_W-1:0] IDX_TIMER_SYSTEM_CONTROL = 8'h86;
  localparam logic [IDX_W-1:0] IDX_CMP_UPPER = 8'h88;
  localparam logic [IDX_W-1:0] IDX_CMP_LOWER = 8'h89;
  localparam logic [IDX_W-1:0] IDX_EDGE_UPPER = 8'h8A;
  localparam logic [IDX_W-1:0] IDX_EDGE_LOWER = 8'h8B;
  localparam logic [IDX_W-1:0] IDX_CH_IRQ_MASK = 8'h8C;
  localparam logic [IDX_W-1:0] IDX_OVF_PRESCALE = 8'h8D;
  localparam logic [IDX_W-1:0] IDX_CH_FLAGS = 8'h8E;
  localparam logic [IDX_W-1:0] IDX_OVF_FLAGS = 8'h8F;
  localparam logic [IDX_W-1:0] IDX_CH0 = 8'h90;
  localparam logic [IDX_W-1:0] IDX_CH1 = 8'h92;
  localparam logic [IDX_W-1:0] IDX_CH2 = 8'h94;
  localparam logic [IDX_W-1:0] IDX_CH3 = 8'h96;
  localparam logic [IDX_W-1:0] IDX_CH4 = 8'h98;
  localparam logic [IDX_W-1:0] IDX_CH5 = 8'h9A;
  localparam logic [IDX_W-1:0] IDX_CH6 = 8'h9C;
  localparam logic [IDX_W-1:0] IDX_CH7 = 8'h9E;
  localparam logic [IDX_W-1:0] IDX_ACC_CTL = 8'hA0;
  localparam logic [IDX_W-1:0] IDX_ACC_FLAGS = 8'hA1;
  localparam logic [IDX_W-1:0] IDX_ACC_CNT = 8'hA2;

  // Field positions
  localparam int TIMER_SYSTEM_CONTROL_RUN_BIT = 7;
  localparam int TIMER_SYSTEM_CONTROL_WAIT_BIT = 6;
  localparam int TIMER_SYSTEM_CONTROL_DEBUG_BIT = 5;
  localparam int TIMER_SYSTEM_CONTROL_FAST_BIT = 4;
  localparam int OVP_IRQ_BIT = 7;
  localparam int OVP_CRST_BIT = 3;
  localparam int OVP_PR_LSB = 0;
  localparam int OVF_FLAG_BIT = 7;
  localparam int ACC_EN_BIT = 6;
  localparam int ACC_GATED_BIT = 5;
  localparam int ACC_EDGE_BIT = 4;
  localparam int ACC_OVF_BIT = 1;
  localparam int ACC_IN_BIT = 0;

  // Values
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  localparam int PRE_W = 6;
  localparam logic [2:0] PRE_MAX_SHIFT = 3'h5;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DONE = 2'b11,
    BUS_WR = 2'b10
  } tcc_bus_t;

  // {hit, channel} for a channel value index
  function automatic logic [3:0] tcc_ch_decode(input logic [IDX_W-1:0] idx);
    tcc_ch_decode = {(idx[7:4] == IDX_CH0[7:4]) && !idx[0], idx[3:1]};
  endfunction : tcc_ch_decode

endpackage : tcc_pkg

// ==== verilog/tcc_prescaler.sv ====
`timescale 1ns/1ps
module tcc_prescaler #(
  parameter int STAGES = tcc_pkg::PRE_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  // Ticks
  output logic count_tick_out,
  output logic slow_tick_out
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] cnt;
    logic [2:0] shift;
  } tcc_pre_state_t;

  tcc_pre_state_t s;
  tcc_pre_state_t next_s;
  logic [STAGES-1:0] mask;

  always_comb begin
    next_s = s;
    mask = STAGES'((1 << s.shift) - 1);
    if (run_in) begin
      next_s.cnt = s.cnt + 1'b1;
      // Divisor swaps only with all stages at zero, so no short first period unless the old divisor was 1
      if (s.cnt == '0) begin
        next_s.shift = (sel_in > PRE_MAX_SHIFT) ? PRE_MAX_SHIFT : sel_in;
      end
    end
  end

  assign count_tick_out = run_in & ((s.cnt & mask) == mask);
  assign slow_tick_out = run_in & (s.cnt == '1);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : tcc_prescaler

// ==== verif/tcc_timer_monitor.sv ====
`timescale 1ns/1ps
module tcc_timer_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [tcc_pkg::DATA_W-1:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Requests and ticks
  input wire logic [tcc_pkg::NCH-1:0] channel_irq_out,
  input wire logic overflow_irq_out,
  input wire logic accum_div64_tick_out
);
  import tcc_pkg::*;
  logic taken;
  logic dphase;
  logic seen;
  logic [7:0] gap;
  assign taken = hsel_in && htrans_in[1] && hready_in && hreadyout_out;
  // Gap saturates so a long halt cannot wrap it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dphase <= 1'b0;
      seen <= 1'b0;
      gap <= 8'h00;
    end else begin
      dphase <= taken;
      seen <= seen | accum_div64_tick_out;
      gap <= accum_div64_tick_out ? 8'h00 : (gap == 8'hFF ? gap : gap + 8'h01);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  a_write_no_wait: assert property (taken && hwrite_in |=> hreadyout_out)
    else $error("write was stalled");
  a_read_one_wait: assert property (taken && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  a_wait_after_read: assert property (!hreadyout_out |-> $past(taken && !hwrite_in))
    else $error("stall without a read");
  a_rdata_hold: assert property (!$past(rst_in) && hrdata_out != $past(hrdata_out) |-> !$past(hreadyout_out))
    else $error("read data changed outside a read");
  a_reset_state: assert property (disable iff (1'b0) rst_in |=> hreadyout_out && hrdata_out == RD_ZERO
    && channel_irq_out == 8'h00 && !overflow_irq_out) else $error("reset state wrong");
  a_tick_spacing: assert property (accum_div64_tick_out && seen |-> gap >= 8'd63)
    else $error("div64 ticks too close");
  a_flag_clear_bus: assert property (!$past(rst_in) && (|($past(channel_irq_out) & ~channel_irq_out))
    |-> $past(dphase)) else $error("channel request dropped without access");
  a_wrap_clear_bus: assert property (!$past(rst_in) && $fell(overflow_irq_out) |-> $past(dphase))
    else $error("wrap request dropped without access");
endmodule : tcc_timer_monitor

bind tcc_timer tcc_timer_monitor u_monitor (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .channel_irq_out(channel_irq_out),
  .overflow_irq_out(overflow_irq_out), .accum_div64_tick_out(accum_div64_tick_out));

// ==== verif/tcc_pin_model.sv ====
`timescale 1ns/1ps
module tcc_pin_model (
  // Timer drive
  input wire logic [tcc_pkg::NCH-1:0] pin_out_in,
  input wire logic [tcc_pkg::NCH-1:0] pin_oe_in,
  // External sources
  input wire logic [tcc_pkg::NCH-1:0] ext_level_in,
  // Resolved pins
  output logic [tcc_pkg::NCH-1:0] level_out
);
  import tcc_pkg::*;
  // Timer wins where it drives; sources never fight it
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule : tcc_pin_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import tcc_pkg::*;
  localparam logic [7:0] RIX [11] = '{IDX_IOS, IDX_TIMER_SYSTEM_CONTROL, IDX_CMP_LOWER, IDX_EDGE_LOWER, IDX_CH_IRQ_MASK,
    IDX_OVF_PRESCALE, IDX_CH_FLAGS, IDX_OVF_FLAGS, IDX_CH0, IDX_CH7, 8'h7F};
  localparam logic [10:0] MT [6] = '{11'h401, 11'h000, 11'h604, 11'h405, 11'h502, 11'h403};
  localparam logic [1:0] OC [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
  logic clk_in, rst_in, hsel, hwr, hrdy, hresp, wmode, dmode, ovf, tick;
  logic [1:0] htr;
  logic [31:0] haddr, hwd, hrd;
  logic [7:0] dir, pdat, ext, lvl, po, poe, cirq;
  int fails = 0;
  int n_compared = 0;
  int seed = 30;
  int ticks = 0;
  tcc_timer uut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htr),
    .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(hrdy), .hrdata_out(hrd),
    .hreadyout_out(hrdy), .hresp_out(hresp), .wait_mode_in(wmode), .debug_mode_in(dmode), .pin_in(lvl),
    .port_direction_bits_in(dir), .port_data_in(pdat), .pin_out(po), .pin_oe_out(poe),
    .channel_irq_out(cirq), .overflow_irq_out(ovf), .accum_div64_tick_out(tick));
  tcc_pin_model u_pins (.pin_out_in(po), .pin_oe_in(poe), .ext_level_in(ext), .level_out(lvl));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (tick === 1'b1) ticks <= ticks + 1;
  task automatic complete_run;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Called just after a rising edge; waits on hready, never on a cycle count
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htr <= 2'b10;
    hwr <= w;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    htr <= 2'b00;
    hwd <= wd;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    rd = hrd;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] t;
    bus(1'b1, idx, wd, t);
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    bus(1'b0, idx, 32'h0, v);
  endtask : rd
  function automatic logic exp_pin(input logic [1:0] code, input logic prev);
    return code == 2'b01 ? ~prev : (code == 2'b00 ? prev : code[0]);
  endfunction : exp_pin
  function automatic int divisor(input int code);
    return code >= 5 ? 32 : 1 << code;
  endfunction : divisor
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  initial begin
    logic [31:0] v, c;
    logic [15:0] dv;
    logic p;
    int n, e, w;
    {rst_in, hsel, hwr, wmode, dmode, htr, haddr, hwd, dir, pdat, ext} = {1'b1, 94'h0};
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    wr(8'h7F, 32'hFFFF_FFFF);
    foreach (RIX[i]) begin
      rd(RIX[i], v);
      check("reset or unmapped", v, RD_ZERO);
    end
    wr(IDX_CH_IRQ_MASK, 32'hFF);
    wr(IDX_IOS, 32'h81);
    wr(IDX_CH1, 32'h5555);
    rd(IDX_CH1, v);
    check("capture channel write", v, RD_ZERO);
    // Channel 7 still holds zero from reset, so the counter never leaves zero
    wr(IDX_OVF_PRESCALE, 32'h08);
    wr(IDX_TIMER_SYSTEM_CONTROL, 32'h80);
    for (n = 0; n < 3; n++) begin
      rd(IDX_FREE_CNT, v);
      check("counter held", v, RD_ZERO);
    end
    wr(IDX_CH7, 32'd20);
    for (n = 0; n < 4; n++) begin
      repeat (8 + ($random(seed) & 31)) @(posedge clk_in);
      rd(IDX_FREE_CNT, v);
      check("counter reset", 32'(v <= 32'd20), 32'h1);
    end
    wr(IDX_OVF_PRESCALE, 32'h0);
    foreach (MT[i]) begin
      wr(IDX_TIMER_SYSTEM_CONTROL, {24'h0, MT[i][10:3]});
      wmode <= MT[i][2];
      dmode <= MT[i][1];
      rd(IDX_FREE_CNT, c);
      n = ticks;
      repeat (130) @(posedge clk_in);
      rd(IDX_FREE_CNT, v);
      check("counter runs", 32'(v != c), 32'(MT[i][0]));
      check("div64 ticks", 32'(ticks != n), 32'(MT[i][0]));
    end
    wmode <= 1'b0;
    dmode <= 1'b0;
    for (e = 0; e < 9; e++) begin
      wr(IDX_OVF_PRESCALE, 32'(e % 8));
      repeat (70) @(posedge clk_in);
      rd(IDX_FREE_CNT, c);
      repeat (189) @(posedge clk_in);
      rd(IDX_FREE_CNT, v);
      dv = v[15:0] - c[15:0];
      w = 192 / divisor(e % 8);
      check("prescale rate", 32'(int'(dv) >= w - 1 && int'(dv) <= w + 1), 32'h1);
    end
    p = 1'b0;
    for (e = 0; e < 4; e++) begin
      pdat <= 8'($random(seed));
      dir <= 8'($random(seed)) & 8'h7A;
      wr(IDX_CMP_LOWER, 32'h0);
      wr(IDX_CH_FLAGS, 32'hFF);
      check("pin released", {30'h0, poe[0], po[0]}, {30'h0, 1'b0, pdat[0]});
      wr(IDX_CMP_LOWER, {30'h0, OC[e]});
      rd(IDX_FREE_CNT, c);
      wr(IDX_CH0, c + 32'd24 + 32'($random(seed) & 15));
      for (n = 0; n < 200 && cirq[0] !== 1'b1; n++) @(posedge clk_in);
      p = exp_pin(OC[e], p);
      check("compare pin", {30'h0, poe[0], po[0]}, {30'h0, 1'b1, p});
      wr(IDX_CH_IRQ_MASK, 32'hFE);
      check("masked request", 32'(cirq[0]), 32'h0);
      wr(IDX_CH_IRQ_MASK, 32'hFF);
      wr(IDX_CH_FLAGS, 32'h0);
      check("flag kept", 32'(cirq[0]), 32'h1);
      wr(IDX_CH_FLAGS, 32'h1);
      check("flag cleared", 32'(cirq[0]), 32'h0);
    end
    wr(IDX_OVF_FLAGS, 32'h80);
    wr(IDX_OVF_PRESCALE, 32'h80);
    for (n = 0; n < 70000 && ovf !== 1'b1; n++) @(posedge clk_in);
    rd(IDX_OVF_FLAGS, v);
    check("wrap flag", v, 32'h80);
    wr(IDX_OVF_PRESCALE, 32'h0);
    check("wrap masked", 32'(ovf), 32'h0);
    wr(IDX_OVF_PRESCALE, 32'h80);
    wr(IDX_OVF_FLAGS, 32'h0);
    check("wrap kept", 32'(ovf), 32'h1);
    wr(IDX_OVF_FLAGS, 32'h80);
    check("wrap cleared", 32'(ovf), 32'h0);
    // Timer halted so every capture must latch the same count
    wr(IDX_TIMER_SYSTEM_CONTROL, 32'h0);
    rd(IDX_FREE_CNT, c);
    for (e = 0; e < 4; e++) begin
      wr(IDX_EDGE_LOWER, 32'(e) << 4);
      wr(IDX_CH_FLAGS, 32'hFF);
      ext[2] <= 1'b1;
      repeat (4) @(posedge clk_in);
      check("rising capture", 32'(cirq[2]), 32'(e & 1));
      wr(IDX_CH_FLAGS, 32'h4);
      ext[2] <= 1'b0;
      repeat (4) @(posedge clk_in);
      check("falling capture", 32'(cirq[2]), 32'((e >> 1) & 1));
      rd(IDX_CH2, v);
      check("captured value", v, e == 0 ? RD_ZERO : c);
    end
    wr(IDX_TIMER_SYSTEM_CONTROL, 32'h10);
    ext[2] <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("capture before read", 32'(cirq[2]), 32'h1);
    rd(IDX_CH2, v);
    @(posedge clk_in);
    check("fast clear on read", 32'(cirq[2]), 32'h0);
    // Debug halt selected and active; event counting must carry on
    wr(IDX_TIMER_SYSTEM_CONTROL, 32'h30);
    dmode <= 1'b1;
    // Channel 7 compare code stays 00, leaving its pin to the accumulator
    wr(IDX_ACC_CTL, 32'h50);
    ext[7] <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(IDX_ACC_FLAGS, v);
    check("accum input flag", v, 32'h1);
    rd(IDX_ACC_CNT, v);
    check("accum count", v, 32'h1);
    rd(IDX_ACC_FLAGS, v);
    check("accum fast clear", v, RD_ZERO);
    complete_run();
  end
endmodule : testbench
